//--- hw/sarseq_defines.svh
`ifndef SARSEQ_DEFINES_SVH
`define SARSEQ_DEFINES_SVH
// register byte offsets
`define SARSEQ_OFS_MODE 12'h000
`define SARSEQ_OFS_CHAN 12'h004
`define SARSEQ_OFS_WORD 12'h008
`define SARSEQ_OFS_BYTE 12'h00c
`define SARSEQ_OFS_STAT 12'h010
`define SARSEQ_OFS_PCFG 12'h014
// mode register fields
`define SARSEQ_MODE_CE_BIT 0
`define SARSEQ_MODE_TSEL_LO 1
`define SARSEQ_MODE_TSEL_HI 6
`define SARSEQ_MODE_RUN_BIT 7
// channel field
`define SARSEQ_CHAN_HI 2
// reset values
`define SARSEQ_MODE_RST 8'h00
`define SARSEQ_CHAN_RST 3'h0
`define SARSEQ_WORD_RST 16'h0000
`define SARSEQ_BYTE_RST 8'h00
`define SARSEQ_PCFG_RST 8'h08
// timing: sample phase base and per-bit base cycles, extended by time select
`define SARSEQ_SAMPLE_BASE 8'h04
`define SARSEQ_BIT_BASE 8'h02
`define SARSEQ_RESULT_SHIFT 6
`define SARSEQ_NBITS 4'h9
// axi responses
`define SARSEQ_RESP_OKAY 2'h0
`define SARSEQ_RESP_SLVERR 2'h2
`endif

//--- hw/sarseq_pkg.sv
package sarseq_pkg;
    typedef enum logic [1:0] {
        SARSEQ_IDLE,
        SARSEQ_SAMPLE,
        SARSEQ_CONVERT
    } sarseq_state_t;

    // analog front-end controls bundled
    typedef struct packed {
        logic comparator_enable;
        logic sample_en;
        logic hold_en;
        logic [2:0] channel_field;
        logic [9:0] tap_code;
    } sarseq_afe_t;
endpackage : sarseq_pkg

//--- hw/sarseq_top.sv
`timescale 1ns/1ps
`include "sarseq_defines.svh"
// How it works
// RL1 - mode bit 0 powers the comparator on or off.
// RL2 - mode bits 6 to 1 set the conversion duration.
// RL3 - mode bit 7 starts conversion of the selected channel.
// RL4 - sample for a fixed interval, then hold until conversion ends.
// RL5 - after hold, set approximation bit 9 and select half-reference tap.
// RL6 - msb stays 1 if input at least the tap, else cleared.
// RL7 - bit 8 trial uses quarter taps; stays 1 if input at least tap.
// RL8 - trial and compare repeats down to bit 0.
// RL9 - after ten bits, latch result and raise done request together.
// RL10 - while run stays 1, next conversion starts right after completion.
// RL11 - channel write aborts conversion; restarts from sampling if running.
// RL12 - clearing run stops at once; result keeps previous value.
// RL13 - reset clears word and byte result registers to zero.
// RL14 - word result is the 10-bit value shifted left by six.
// RL15 - byte result holds an 8-bit form of each result.
// RL16 - channel field bits 2 to 0 choose the converted input.
// RL17 - only single-channel select mode exists.
// RL18 - software waits 1 us from comparator enable to run.
// RL19 - without prior enable, software discards first result.
// RL20 - software configures pin as analog input before starting.
// RL21 - channel write to next done equals configured conversion time.
// RL22 - control write at conversion end wins; no update, no request.
// RL23 - channel write does not clear a pending done flag.
// RL24 - clearing run returns sequencer to idle for fresh sampling.
module sarseq_top (
    input wire logic clk,
    input wire logic srst,
    // register bus
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // analog front end
    input wire logic comparator_out,
    output sarseq_pkg::sarseq_afe_t afe_q,
    output logic conversion_done_irq
);
    // ==========================================================
    // helpers
    // ==========================================================
    // per-bit period grows with time select so longer settings give slower conversions
    function automatic logic [7:0] bit_period(input logic [5:0] tsel);
        bit_period = `SARSEQ_BIT_BASE + {2'h0, tsel};
    endfunction : bit_period

    // sampling grows twice as fast so slow settings still settle the hold capacitor
    function automatic logic [7:0] sample_period(input logic [5:0] tsel);
        sample_period = `SARSEQ_SAMPLE_BASE + {1'h0, tsel, 1'h0};
    endfunction : sample_period

    // time select field pulled out once so every reload uses the same bits
    function automatic logic [5:0] tsel_of(input logic [7:0] mode);
        tsel_of = mode[`SARSEQ_MODE_TSEL_HI:`SARSEQ_MODE_TSEL_LO];
    endfunction : tsel_of

    // ==========================================================
    // register bus
    // ==========================================================
    // software visible state
    logic [7:0] mode_q, mode_d;
    logic [2:0] chan_q, chan_d;
    logic [7:0] pcfg_q, pcfg_d;
    logic [15:0] word_q, word_d;
    logic [7:0] byte_q, byte_d;
    logic flag_q, flag_d;

    // write channel holding registers
    logic [11:0] awaddr_q, awaddr_d;
    logic aw_have_q, aw_have_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic w_have_q, w_have_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;

    // read channel registers
    logic rvalid_q, rvalid_d;
    logic [1:0] rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic awready_q, wready_q, arready_q;

    // decoded write strobes, one per writable register (word and byte have none)
    logic wr_fire;
    logic mode_wr, chan_wr, pcfg_wr, stat_wr;

    // sequencer results seen by the register side
    logic conv_done;
    logic busy_q;
    logic [9:0] sar_q, sar_d;

    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
    assign mode_wr = wr_fire && awaddr_q == `SARSEQ_OFS_MODE && wstrb_q[0];
    assign chan_wr = wr_fire && awaddr_q == `SARSEQ_OFS_CHAN && wstrb_q[0];
    assign pcfg_wr = wr_fire && awaddr_q == `SARSEQ_OFS_PCFG && wstrb_q[0];
    assign stat_wr = wr_fire && awaddr_q == `SARSEQ_OFS_STAT && wstrb_q[0];

    // address and data captured independently, write performed once both held
    // the next write waits until the previous response has retired
    always_comb begin
        awaddr_d = awaddr_q;
        aw_have_d = aw_have_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        w_have_d = w_have_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        // address taken whenever its holding slot is empty
        if (s_axi_awvalid && awready_q) begin
            awaddr_d = s_axi_awaddr;
            aw_have_d = 1'b1;
        end
        // data taken on its own, in either order
        if (s_axi_wvalid && wready_q) begin
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
            w_have_d = 1'b1;
        end
        // both halves held: write and answer
        if (wr_fire) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            case (awaddr_q)
                `SARSEQ_OFS_MODE, `SARSEQ_OFS_CHAN, `SARSEQ_OFS_STAT, `SARSEQ_OFS_PCFG,
                `SARSEQ_OFS_WORD, `SARSEQ_OFS_BYTE: bresp_d = `SARSEQ_RESP_OKAY;
                default: bresp_d = `SARSEQ_RESP_SLVERR;
            endcase
        end
        // response retires on its handshake
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
    end

    // control registers; flag set wins over software clear
    always_comb begin
        mode_d = mode_q;
        chan_d = chan_q;
        pcfg_d = pcfg_q;
        flag_d = flag_q;
        // mode bits act from the next cycle
        if (mode_wr) begin
            mode_d = wdata_q[7:0]; // RL1 RL2 RL3
        end
        // channel change reaches the front end together with the restart
        if (chan_wr) begin
            chan_d = wdata_q[`SARSEQ_CHAN_HI:0]; // RL16 RL17
        end
        // pin setup stored only; the pins themselves live outside this block
        if (pcfg_wr) begin
            pcfg_d = wdata_q[7:0];
        end
        // write one clears; a done in the same cycle wins below
        if (stat_wr && wdata_q[0]) begin
            flag_d = 1'b0; // RL23
        end
        if (conv_done) begin
            flag_d = 1'b1;
        end
    end

    // read side: one read at a time, answer one cycle after address taken
    // arready stays low while the answer stands, so reads cannot overlap
    always_comb begin
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        if (s_axi_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rresp_d = `SARSEQ_RESP_OKAY;
            // decoded straight from the bus address, registered with rvalid
            case (s_axi_araddr)
                `SARSEQ_OFS_MODE: rdata_d = {24'h00_0000, mode_q};
                `SARSEQ_OFS_CHAN: rdata_d = {29'h0000_0000, chan_q};
                `SARSEQ_OFS_WORD: rdata_d = {16'h0000, word_q};
                `SARSEQ_OFS_BYTE: rdata_d = {24'h00_0000, byte_q};
                `SARSEQ_OFS_STAT: rdata_d = {20'h0_0000, sar_q, busy_q, flag_q};
                `SARSEQ_OFS_PCFG: rdata_d = {24'h00_0000, pcfg_q};
                default: begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = `SARSEQ_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    // ==========================================================
    // conversion sequencer
    // ==========================================================
    sarseq_pkg::sarseq_state_t state_q, state_d;
    logic [7:0] cnt_q, cnt_d; // cycles left in the current phase
    logic [3:0] bit_q, bit_d; // trial bit under test
    logic ctrl_wr;
    logic run_d;
    logic [5:0] tsel_now, tsel_next;

    // any write that reshapes a conversion counts as a control write
    assign ctrl_wr = mode_wr || chan_wr || pcfg_wr;
    // run as it stands after this cycle, so a stop write acts at once
    assign run_d = mode_d[`SARSEQ_MODE_RUN_BIT];
    assign busy_q = state_q != sarseq_pkg::SARSEQ_IDLE;

    // reloads use the held setting; a restart uses the value being written
    assign tsel_now = tsel_of(mode_q);
    assign tsel_next = tsel_of(mode_d);

    // a control write in the final compare cycle suppresses the result,
    // so software never sees a value taken under a half changed setup
    assign conv_done = state_q == sarseq_pkg::SARSEQ_CONVERT && bit_q == 4'h0
        && cnt_q == 8'h00 && !ctrl_wr; // RL9 RL22

    // phases count down to zero, so each lasts its loaded value plus one;
    // the comparator is sampled only in the last cycle of a bit, which
    // gives the tap and the held level the whole bit time to settle
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        bit_d = bit_q;
        sar_d = sar_q;
        word_d = word_q;
        byte_d = byte_q;
        unique case (state_q)
            sarseq_pkg::SARSEQ_IDLE: begin
                // comparator power is separate; idle only waits for run
                if (mode_q[`SARSEQ_MODE_RUN_BIT]) begin
                    state_d = sarseq_pkg::SARSEQ_SAMPLE; // RL3
                    cnt_d = sample_period(tsel_now);
                end
            end
            sarseq_pkg::SARSEQ_SAMPLE: begin
                // sampling over: hold starts with the msb as first trial
                if (cnt_q == 8'h00) begin
                    state_d = sarseq_pkg::SARSEQ_CONVERT; // RL4
                    bit_d = `SARSEQ_NBITS;
                    sar_d = 10'h200; // RL5
                    cnt_d = bit_period(tsel_now); // RL2
                end else begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
            sarseq_pkg::SARSEQ_CONVERT: begin
                if (cnt_q != 8'h00) begin
                    cnt_d = cnt_q - 8'h01;
                end else begin
                    // resolve current trial bit from comparator
                    sar_d[bit_q] = comparator_out; // RL6 RL7
                    if (bit_q == 4'h0) begin
                        // last bit resolved: results take the finished value
                        if (conv_done) begin
                            word_d = {sar_d, 6'h00}; // RL9 RL14
                            byte_d = sar_d[9:2]; // RL15
                        end
                        state_d = sarseq_pkg::SARSEQ_SAMPLE; // RL10
                        cnt_d = sample_period(tsel_now);
                    end else begin
                        // next lower bit becomes the trial and the tap follows it
                        bit_d = bit_q - 4'h1; // RL8
                        sar_d[bit_q - 4'h1] = 1'b1; // RL7
                        cnt_d = bit_period(tsel_now);
                    end
                end
            end
        endcase
        // a channel write restarts from sampling so the next done is one full conversion
        if (chan_wr && run_d) begin
            state_d = sarseq_pkg::SARSEQ_SAMPLE; // RL11 RL21
            cnt_d = sample_period(tsel_next);
        end
        // clearing run overrides all of the above; the half done value is lost,
        // so the result registers keep the last completed conversion
        if (!run_d) begin
            state_d = sarseq_pkg::SARSEQ_IDLE; // RL12 RL24
            cnt_d = 8'h00;
        end
    end

    // ==========================================================
    // registers
    // ==========================================================
    always_ff @(posedge clk) begin
        if (srst) begin
            // software registers
            mode_q <= `SARSEQ_MODE_RST;
            chan_q <= `SARSEQ_CHAN_RST;
            pcfg_q <= `SARSEQ_PCFG_RST;
            word_q <= `SARSEQ_WORD_RST; // RL13
            byte_q <= `SARSEQ_BYTE_RST; // RL13
            flag_q <= 1'b0;
            // bus handshake state
            awaddr_q <= 12'h000;
            aw_have_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            rvalid_q <= 1'b0;
            rresp_q <= 2'h0;
            rdata_q <= 32'h0000_0000;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            arready_q <= 1'b0;
            // sequencer
            state_q <= sarseq_pkg::SARSEQ_IDLE;
            cnt_q <= 8'h00;
            bit_q <= 4'h0;
            sar_q <= 10'h000;
            // front end quiet and comparator off until software asks
            afe_q <= '0;
            conversion_done_irq <= 1'b0;
        end else begin
            // software registers
            mode_q <= mode_d;
            chan_q <= chan_d;
            pcfg_q <= pcfg_d;
            word_q <= word_d;
            byte_q <= byte_d;
            flag_q <= flag_d;
            // bus handshake state
            awaddr_q <= awaddr_d;
            aw_have_q <= aw_have_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            w_have_q <= w_have_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            awready_q <= !aw_have_d;
            wready_q <= !w_have_d;
            arready_q <= !rvalid_d;
            // sequencer
            state_q <= state_d;
            cnt_q <= cnt_d;
            bit_q <= bit_d;
            sar_q <= sar_d;
            // analog controls registered so the front end sees clean levels
            afe_q.comparator_enable <= mode_d[`SARSEQ_MODE_CE_BIT]; // RL1
            afe_q.sample_en <= state_d == sarseq_pkg::SARSEQ_SAMPLE; // RL4
            afe_q.hold_en <= state_d == sarseq_pkg::SARSEQ_CONVERT; // RL4
            afe_q.channel_field <= chan_d; // RL16
            afe_q.tap_code <= sar_d; // RL5 RL7
            conversion_done_irq <= conv_done; // RL9
        end
    end

    // bus outputs straight from their flops
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
endmodule : sarseq_top

//--- testbench/sarseq_assertions.sv
`timescale 1ns/1ps
`include "sarseq_defines.svh"
// ==========
// sequencing checks
module sarseq_assertions (
    input wire logic clk,
    input wire logic srst,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire sarseq_pkg::sarseq_afe_t afe_q,
    input wire logic conversion_done_irq
);
    logic wr_any, wr_mode, wr_chan, wr_ctrl, run_d, run_q, ce_d, ce_q;
    logic [2:0] chan_d, chan_q;
    // shadows rely on address and data being offered together
    assign wr_any = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    assign wr_mode = wr_any && s_axi_awaddr == `SARSEQ_OFS_MODE;
    assign wr_chan = wr_any && s_axi_awaddr == `SARSEQ_OFS_CHAN;
    assign wr_ctrl = wr_mode || wr_chan || (wr_any && s_axi_awaddr == `SARSEQ_OFS_PCFG);
    // shadow of written run, enable and channel
    always_comb begin
        run_d = srst ? 1'b0 : (wr_mode ? s_axi_wdata[7] : run_q);
        ce_d = srst ? 1'b0 : (wr_mode ? s_axi_wdata[0] : ce_q);
        chan_d = srst ? 3'h0 : (wr_chan ? s_axi_wdata[2:0] : chan_q);
    end
    always_ff @(posedge clk) begin
        run_q <= run_d;
        ce_q <= ce_d;
        chan_q <= chan_d;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_stop; wr_mode && !s_axi_wdata[7]; endsequence
    sequence s_quiet; !afe_q.sample_en && !afe_q.hold_en && !conversion_done_irq; endsequence
    property p_ce; wr_mode |-> ##3 afe_q.comparator_enable == ce_q; endproperty
    property p_excl; !(afe_q.sample_en && afe_q.hold_en); endproperty
    property p_msb; $rose(afe_q.hold_en) |-> ##[0:1] afe_q.tap_code == 10'h200; endproperty
    property p_pulse; conversion_done_irq |=> !conversion_done_irq; endproperty
    property p_rerun; conversion_done_irq && run_q |-> ##[0:2] afe_q.sample_en; endproperty
    property p_stop; s_stop |-> ##4 s_quiet[*4]; endproperty
    property p_restart; wr_chan && run_q |-> ##[2:4] afe_q.sample_en; endproperty
    property p_chan; wr_chan |-> ##[3:5] afe_q.channel_field == chan_q; endproperty
    property p_win; wr_ctrl |-> ##2 !conversion_done_irq; endproperty
    a_ce: assert property (p_ce) else $error("enable mismatch");
    a_excl: assert property (p_excl) else $error("sample and hold overlap");
    a_msb: assert property (p_msb) else $error("first trial not msb");
    a_pulse: assert property (p_pulse) else $error("done pulse too long");
    a_rerun: assert property (p_rerun) else $error("no resample after done");
    a_stop: assert property (p_stop) else $error("run clear did not stop");
    a_restart: assert property (p_restart) else $error("no restart on channel write");
    a_chan: assert property (p_chan) else $error("channel field mismatch");
    a_win: assert property (p_win) else $error("done raised despite control write");
endmodule : sarseq_assertions
bind sarseq_top sarseq_assertions i_sarseq_assertions (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .afe_q, .conversion_done_irq);

//--- testbench/sarseq_afe_model.sv
`timescale 1ns/1ps
// ==========
// analog inputs, sample-and-hold and tap comparator
module sarseq_afe_model (
    input wire logic clk,
    input wire sarseq_pkg::sarseq_afe_t afe,
    input wire logic [7:0][9:0] levels,
    output logic comparator_out
);
    logic [9:0] held_q = 10'h000;
    logic junk_q = 1'b0;
    // held level follows the chosen input only while sampling
    always_ff @(posedge clk) begin
        if (afe.sample_en) begin
            held_q <= levels[afe.channel_field];
        end
        junk_q <= ~junk_q;
    end
    // unpowered or unheld comparator toggles, so stale results cannot pass
    assign comparator_out = (afe.hold_en && afe.comparator_enable) ? (held_q >= afe.tap_code) : junk_q;
endmodule : sarseq_afe_model

//--- testbench/tb.sv
`timescale 1ns/1ps
`include "sarseq_defines.svh"
// ==========
// bench top
module tb;
    logic clk = 1'b0, srst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, cmp, irq;
    logic [1:0] bresp, rresp;
    sarseq_pkg::sarseq_afe_t afe;
    logic [7:0][9:0] levels = {10'h3fe, 10'h001, 10'h2aa, 10'h155, 10'h1ff, 10'h200, 10'h000, 10'h3ff};
    int bad_count = 0, check_count = 0;
    always #5 clk = ~clk;
    sarseq_top i_sarseq_top (.clk(clk), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .comparator_out(cmp),
        .afe_q(afe), .conversion_done_irq(irq));
    sarseq_afe_model i_sarseq_afe_model (.clk(clk), .afe(afe), .levels(levels), .comparator_out(cmp));
    // ==========
    // bus and compare helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask : chk
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // each channel is released at its own handshake
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_rd
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        chk(d, e);
    endtask : rd_chk
    // counts cycles to the next done pulse; a missing pulse is a mismatch
    task automatic wait_irq(output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (irq !== 1'b1 && n < 3000);
        chk({31'h0, irq}, 32'h0000_0001);
    endtask : wait_irq
    // ==========
    // scenarios
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0] r;
        axi_wr(`SARSEQ_OFS_WORD, 32'hffff_ffff);
        rd_chk(`SARSEQ_OFS_WORD, 32'h0000_0000);
        rd_chk(`SARSEQ_OFS_BYTE, 32'h0000_0000);
        rd_chk(`SARSEQ_OFS_MODE, 32'h0000_0000);
        rd_chk(`SARSEQ_OFS_PCFG, 32'h0000_0008);
        axi_rd(12'h020, d, r);
        chk({30'h0, r}, 32'h0000_0002);
        chk(d, 32'h0000_0000);
    endtask : t_reset
    task automatic t_channels();
        int n;
        axi_wr(`SARSEQ_OFS_MODE, 32'h0000_0001);
        repeat (100) @(posedge clk);
        axi_wr(`SARSEQ_OFS_PCFG, 32'h0000_0000);
        // every channel, extremes and alternating patterns
        for (int ch = 0; ch < 8; ch++) begin
            axi_wr(`SARSEQ_OFS_CHAN, 32'(ch));
            if (ch == 0) axi_wr(`SARSEQ_OFS_MODE, 32'h0000_0081);
            wait_irq(n);
            rd_chk(`SARSEQ_OFS_WORD, {16'h0, levels[ch], 6'h0});
            rd_chk(`SARSEQ_OFS_BYTE, {24'h0, levels[ch][9:2]});
        end
    endtask : t_channels
    task automatic t_timing();
        int n0, n1;
        axi_wr(`SARSEQ_OFS_CHAN, 32'h0000_0001);
        wait_irq(n0);
        axi_wr(`SARSEQ_OFS_MODE, 32'h0000_0083);
        axi_wr(`SARSEQ_OFS_CHAN, 32'h0000_0001);
        wait_irq(n1);
        chk(32'(n1 - n0), 32'h0000_000c);
        axi_wr(`SARSEQ_OFS_MODE, 32'h0000_0081);
    endtask : t_timing
    task automatic t_abort();
        logic [31:0] d;
        logic [1:0] r;
        int n;
        axi_wr(`SARSEQ_OFS_CHAN, 32'h0000_0001);
        wait_irq(n);
        repeat (10) @(posedge clk);
        axi_wr(`SARSEQ_OFS_CHAN, 32'h0000_0002);
        axi_rd(`SARSEQ_OFS_STAT, d, r);
        chk({31'h0, d[0]}, 32'h0000_0001);
        axi_wr(`SARSEQ_OFS_STAT, 32'h0000_0001);
        axi_rd(`SARSEQ_OFS_STAT, d, r);
        chk({31'h0, d[0]}, 32'h0000_0000);
        wait_irq(n);
        rd_chk(`SARSEQ_OFS_WORD, 32'h0000_8000);
    endtask : t_abort
    task automatic t_stop();
        int n, hits;
        hits = 0;
        wait_irq(n);
        levels[2] <= 10'h2ab;
        repeat (15) @(posedge clk);
        axi_wr(`SARSEQ_OFS_MODE, 32'h0000_0001);
        repeat (200) begin
            @(posedge clk);
            if (irq === 1'b1) hits++;
        end
        chk(32'(hits), 32'h0000_0000);
        rd_chk(`SARSEQ_OFS_WORD, 32'h0000_8000);
        axi_wr(`SARSEQ_OFS_MODE, 32'h0000_0081);
        wait_irq(n);
        rd_chk(`SARSEQ_OFS_WORD, 32'h0000_aac0);
    endtask : t_stop
    task automatic summarize();
        if (bad_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : summarize
    // ==========
    // main sequence and watchdog
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_channels();
        t_timing();
        t_abort();
        t_stop();
        summarize();
    end
    initial begin
        #200_000;
        bad_count++;
        summarize();
    end
endmodule : tb
